// ### hdl/timer_defines.svh
// Constants for the triple down-counting timer block.
// Assumes inclusion by bare name from every file that needs the figures.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Counter width and number of timers
`define TMR_WIDTH        16
`define TMR_COUNT        3
// Index of the fast third timer, fixed 7.3728 MHz tick source
`define TMR_FAST_INDEX   2

// Reset values
`define TMR_RESET_COUNT  16'h0000
`define TMR_RESET_RELOAD 16'h0000
// Value a free-running counter wraps to on underflow
`define TMR_WRAP_VALUE   16'hFFFF
// Value at which the next tick underflows
`define TMR_ZERO_VALUE   16'h0000
// Decrement step
`define TMR_STEP         16'h0001

// Field positions inside the control struct (msb first)
`define TMR_CTRL_ENABLE_BIT 2
`define TMR_CTRL_MODE_BIT   1
`define TMR_CTRL_SRC_BIT    0

// Slow clock select codes
`define TMR_SEL_508K     1'b0
`define TMR_SEL_2K       1'b1
// Mode codes
`define TMR_MODE_FREE    1'b0
`define TMR_MODE_PERIOD  1'b1

`endif

// ### hdl/timer_pkg.sv
// Types for the triple down-counting timer block.
// Assumes timer_defines.svh is on the include path.
`include "timer_defines.svh"

package timer_pkg;

   typedef enum logic {
      MODE_FREE     = `TMR_MODE_FREE,
      MODE_PERIODIC = `TMR_MODE_PERIOD
   } mode_t;

   typedef enum logic {
      SRC_508K = `TMR_SEL_508K,
      SRC_2K   = `TMR_SEL_2K
   } slow_src_t;

   // Control bits of one timer; src is ignored by the fast timer
   typedef struct packed {
      logic      enable;
      mode_t     mode;
      slow_src_t src;
   } timer_ctrl_t;

   // One-cycle software actions on one timer
   typedef struct packed {
      logic                  load_wr;
      logic                  clear;
      logic [`TMR_WIDTH-1:0] load_data;
   } timer_cmd_t;

endpackage

// ### hdl/tick_sync.sv
// Two-flop synchroniser with rising-edge detector for an external tick clock.
// Assumes the input toggles well below half the system clock rate.
`timescale 1ns/1ps

module tick_sync (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic src_i,
   output logic      tick_o
);

   logic meta;
   logic stable;
   logic prev;
   logic next_tick;

   // Edge seen only after the second flop; the first flop feeds nothing else
   always_comb begin
      next_tick = stable & ~prev;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         meta   <= src_i;
         stable <= meta;
         prev   <= stable;
         tick_o <= next_tick;
      end
   end

endmodule

// ### hdl/triple_down_counter_timers.sv
// Three 16-bit down-counting timers with underflow interrupts.
// Assumes tick clocks arrive as pins asynchronous to clk_i; control comes from
// same-clock logic as levels (ctrl_i) and one-cycle strobes (cmd_i).
`timescale 1ns/1ps
`include "timer_defines.svh"

module triple_down_counter_timers (
   input  wire logic                                      clk_i,
   input  wire logic                                      rstn_i,
   input  wire logic                                      slow_508k_clk_i,
   input  wire logic                                      slow_2k_clk_i,
   input  wire logic                                      fast_third_timer_clk_i,
   input  wire timer_pkg::timer_ctrl_t [`TMR_COUNT-1:0]   ctrl_i,
   input  wire timer_pkg::timer_cmd_t  [`TMR_COUNT-1:0]   cmd_i,
   output wire logic [`TMR_COUNT-1:0][`TMR_WIDTH-1:0]     count_o,
   output wire logic [`TMR_COUNT-1:0]                     irq_o
);

   logic tick_508k;
   logic tick_2k;
   logic tick_fast;

   // Pin clocks pass three flops (two synchroniser, one registered edge) before the counters see them
   tick_sync sync_508k (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .src_i  (slow_508k_clk_i),
      .tick_o (tick_508k)
   );

   tick_sync sync_2k (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .src_i  (slow_2k_clk_i),
      .tick_o (tick_2k)
   );

   tick_sync sync_fast (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .src_i  (fast_third_timer_clk_i),
      .tick_o (tick_fast)
   );

   genvar gi;
   generate
      for (gi = 0; gi < `TMR_COUNT; gi = gi + 1) begin : g_timer
         logic                  tick;
         logic [`TMR_WIDTH-1:0] count;
         logic [`TMR_WIDTH-1:0] next_count;
         logic [`TMR_WIDTH-1:0] reload;
         logic [`TMR_WIDTH-1:0] next_reload;
         logic                  irq;
         logic                  next_irq;

         if (gi == `TMR_FAST_INDEX) begin : g_fast
            always_comb begin
               tick = tick_fast;
            end
         end else begin : g_slow
            always_comb begin
               if (ctrl_i[gi].src == timer_pkg::SRC_2K) begin
                  tick = tick_2k;
               end else begin
                  tick = tick_508k;
               end
            end
         end

         always_comb begin
            next_count  = count;
            next_reload = reload;
            next_irq    = irq;
            if (cmd_i[gi].clear) begin
               next_irq = 1'b0;
            end
            // immediate load; a tick in the same cycle is dropped
            if (cmd_i[gi].load_wr) begin
               next_count  = cmd_i[gi].load_data;
               next_reload = cmd_i[gi].load_data;
            end else if (ctrl_i[gi].enable && tick) begin
               if (count == `TMR_ZERO_VALUE) begin
                  // underflow sets interrupt, winning over a clear
                  next_irq = 1'b1;
                  if (ctrl_i[gi].mode == timer_pkg::MODE_PERIODIC) begin
                     next_count = reload;
                  end else begin
                     next_count = `TMR_WRAP_VALUE;
                  end
               end else begin
                  next_count = count - `TMR_STEP;
               end
            end
         end

         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               count  <= `TMR_RESET_COUNT;
               reload <= `TMR_RESET_RELOAD;
               irq    <= 1'b0;
            end else begin
               count  <= next_count;
               reload <= next_reload;
               irq    <= next_irq;
            end
         end

         assign count_o[gi] = count;
         assign irq_o[gi]   = irq;
      end
   endgenerate

endmodule

// ### verification/timer_chk_properties.sv
// Port checker for the triple timer block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module timer_chk (
   input wire logic                         clk_i,
   input wire logic                         rstn_i,
   input wire timer_pkg::timer_ctrl_t [2:0] ctrl_i,
   input wire timer_pkg::timer_cmd_t  [2:0] cmd_i,
   input wire logic [2:0][15:0]             count_o,
   input wire logic [2:0]                   irq_o
);
   logic [15:0] rl;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Reload copy, so periodic wrap is checked against software's value
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) rl <= 16'h0000;
      else if (cmd_i[1].load_wr) rl <= cmd_i[1].load_data;
   end
   property p_ld0; cmd_i[0].load_wr |=> count_o[0] == $past(cmd_i[0].load_data); endproperty
   a_ld0: assert property (p_ld0) else $error("load lost");
   property p_ld2; cmd_i[2].load_wr |=> count_o[2] == $past(cmd_i[2].load_data); endproperty
   a_ld2: assert property (p_ld2) else $error("fast load lost");
   property p_irq; $rose(irq_o[0]) |-> $past(count_o[0]) == 16'h0000
      && !$past(cmd_i[0].load_wr) && $past(ctrl_i[0].enable); endproperty
   a_irq: assert property (p_irq) else $error("stray irq");
   property p_hold; !ctrl_i[0].enable && !cmd_i[0].load_wr
      |=> $stable(count_o[0]) && !$rose(irq_o[0]); endproperty
   a_hold: assert property (p_hold) else $error("disabled moved");
   property p_step; $changed(count_o[2]) && !$past(cmd_i[2].load_wr)
      |-> count_o[2] == $past(count_o[2]) - 16'h0001 || $past(count_o[2]) == 16'h0000;
   endproperty
   a_step: assert property (p_step) else $error("bad step");
   property p_wrap; $changed(count_o[0]) && $past(count_o[0]) == 16'h0000 && !$past(cmd_i[0].
      load_wr) && $past(ctrl_i[0].mode) == timer_pkg::MODE_FREE |-> count_o[0] == 16'hFFFF;
   endproperty
   a_wrap: assert property (p_wrap) else $error("bad wrap");
   property p_per; $changed(count_o[1]) && $past(count_o[1]) == 16'h0000 && !$past(cmd_i[1].
      load_wr) && $past(ctrl_i[1].mode) == timer_pkg::MODE_PERIODIC |-> count_o[1] == rl;
   endproperty
   a_per: assert property (p_per) else $error("bad reload");
   property p_clr; cmd_i[1].clear && count_o[1] != 16'h0000 |=> !irq_o[1]; endproperty
   a_clr: assert property (p_clr) else $error("irq kept");
endmodule
bind triple_down_counter_timers timer_chk chk_u (.clk_i, .rstn_i, .ctrl_i, .cmd_i, .count_o,
   .irq_o);

// ### verification/triple_down_counter_timers_test.sv
// Random bench with an integer model of the three timers.
// Assumes the design and checker are compiled first.
`timescale 1ns/1ps
module triple_down_counter_timers_test;
   logic                         clk_i = 0;
   logic                         rstn_i = 0;
   logic [2:0]                   pin = 0;
   timer_pkg::timer_ctrl_t [2:0] ctrl = '0;
   timer_pkg::timer_cmd_t  [2:0] cmd = '0;
   logic [2:0][15:0]             cnt;
   logic [2:0]                   irq;
   int                           err_total = 0;
   int                           n_compared = 0;
   int                           m[3], r[3], q[3];
   always #2 clk_i = ~clk_i;
   triple_down_counter_timers dut_u (.clk_i, .rstn_i, .slow_508k_clk_i(pin[0]),
      .slow_2k_clk_i(pin[1]), .fast_third_timer_clk_i(pin[2]), .ctrl_i(ctrl), .cmd_i(cmd),
      .count_o(cnt), .irq_o(irq));
   // One pin pulse, then the model steps every enabled timer fed by that pin
   task automatic tick(int p);
      pin[p] <= 1'b1;
      repeat (4) @(posedge clk_i);
      pin[p] <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int t = 0; t < 3; t++)
         if (ctrl[t].enable && (t == 2 ? p == 2 : p == int'(ctrl[t].src))) begin
            if (m[t] == 0) begin
               q[t] = 1;
               m[t] = ctrl[t].mode ? r[t] : 'hFFFF;
            end else m[t]--;
         end
   endtask
   task automatic go(int t, bit ld, bit cl, logic [15:0] v);
      cmd[t] <= '{ld, cl, v};
      @(posedge clk_i);
      cmd[t] <= '0;
      @(posedge clk_i);
      if (ld) begin m[t] = v; r[t] = v; end
      if (cl) q[t] = 0;
   endtask
   task automatic chk;
      repeat (3) @(posedge clk_i);
      for (int t = 0; t < 3; t++) begin
         n_compared++;
         if (cnt[t] !== 16'(m[t]) || irq[t] !== q[t][0]) begin
            err_total++;
            $display("BAD %0t %h %h", $time, {irq[t], cnt[t]}, {q[t][0], 16'(m[t])});
         end
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      void'($urandom(32'he964_1c98));
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      chk();
      for (int i = 0; i < 80; i++) begin
         ctrl <= 9'($urandom);
         @(posedge clk_i);
         go($urandom % 3, 1'($urandom), 1'($urandom), 16'($urandom % 4));
         repeat ($urandom % 6) tick($urandom % 3);
         chk();
      end
      print_verdict();
   end
   initial begin
      #200us;
      err_total++;
      print_verdict();
   end
endmodule
